// ===== logic/fsg_pkg.sv
/*
  fsg_pkg: shared constants for the frame sync generator.
  assumes: byte-wide registers, one per 32-bit Wishbone word.
*/
package fsg_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] FSG_IDX_RESERVED = 8'h17;
  localparam logic [7:0] FSG_IDX_CTL      = 8'h18;
  localparam logic [7:0] FSG_IDX_HI_UP    = 8'h19;
  localparam logic [7:0] FSG_IDX_HI_LO    = 8'h1a;
  localparam logic [7:0] FSG_IDX_LO_UP    = 8'h1b;
  localparam logic [7:0] FSG_IDX_LO_LO    = 8'h1c;
  localparam logic [7:0] FSG_IDX_STATUS   = 8'h1d;
  localparam logic [7:0] FSG_RESET_BYTE   = 8'h00;

  // control field positions
  localparam int FSG_BIT_ENABLE = 0;
  localparam int FSG_BIT_SCHEME = 1;
  localparam int FSG_BIT_IDLE   = 2;
  localparam int FSG_BIT_SHOT   = 3;
  localparam int FSG_SRC_LSB    = 4;

  // source selector codes
  localparam logic [3:0] FSG_SRC_PORT0 = 4'h0;
  localparam logic [3:0] FSG_SRC_PORT1 = 4'h1;
  localparam logic [3:0] FSG_SRC_EXT5B = 4'he;
  localparam logic [1:0] FSG_SRC_FIX   = 2'h1;
  localparam logic       FSG_SRC_EXT   = 1'b1;

  // fixed reference rate and derived divider
  localparam int FSG_CLK_HZ   = 125_000_000;
  localparam int FSG_FIX_HZ   = 25_000_000;
  localparam int FSG_FIX_DIV  = FSG_CLK_HZ / FSG_FIX_HZ;
  localparam int FSG_NUM_GPIO = 6;

  typedef enum logic [1:0] {
    FSG_IDLE  = 2'b00,
    FSG_HIGH  = 2'b01,
    FSG_LOW   = 2'b10,
    FSG_SHOT  = 2'b11
  } fsg_state_e;
endpackage : fsg_pkg

// ===== logic/fsg_sync3.sv
/*
  fsg_sync3: three-flop synchroniser with agreement filter.
  assumes: input is asynchronous to clk_in.
*/
`timescale 1ns/1ps
module fsg_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] s1, s2, s3, lvl;
  logic [W-1:0] next_lvl;

  always_comb begin
    next_lvl = lvl;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) begin
        next_lvl[i] = s2[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1  <= '0;
      s2  <= '0;
      s3  <= '0;
      lvl <= '0;
    end else begin
      s1  <= async_in;
      s2  <= s1;
      s3  <= s2;
      lvl <= next_lvl;
    end
  end

  assign level_out = lvl;
endmodule : fsg_sync3

// ===== logic/fsg_frame_sync_generator.sv
/*
  fsg_frame_sync_generator: programmable frame sync pulse generator
  with a classic Wishbone register slave.
  assumes: frame clocks and general pins are asynchronous, sampled by fsg_sync3.
*/
`timescale 1ns/1ps
module fsg_frame_sync_generator
  import fsg_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [31:0] wb_adr_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic [3:0]  wb_sel_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        port0_frame_clk_in,
  input  wire logic        port1_frame_clk_in,
  input  wire logic [5:0]  general_pin_in,
  output logic             frame_trigger_out
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0]  sync_source_select;
  logic        idle_level;
  logic        period_scheme;
  logic        periodic_generator_enable;
  logic        one_shot_pulse;
  logic [7:0]  high_time_upper_byte, high_time_lower_byte;
  logic [7:0]  low_time_upper_byte, low_time_lower_byte;
  logic        ack;
  logic [31:0] rdata;
  logic [3:0]  next_src;
  logic        next_idle, next_scheme, next_en, next_shot;
  logic [7:0]  next_hu, next_hl, next_lu, next_ll;
  logic        next_ack;
  logic [31:0] next_rdata;

  function automatic logic hit(input logic [31:0] adr, input logic [7:0] idx);
    hit = (adr[1:0] == 2'b00) && (adr[31:2] == {22'h0, idx});
  endfunction : hit

  logic req, wr;
  assign req = wb_cyc_in && wb_stb_in && !ack;
  assign wr  = req && wb_we_in && wb_sel_in[0];

  fsg_state_e state;
  logic       sync_q;

  always_comb begin
    next_src    = sync_source_select;
    next_idle   = idle_level;
    next_scheme = period_scheme;
    next_en     = periodic_generator_enable;
    next_shot   = 1'b0;
    next_hu     = high_time_upper_byte;
    next_hl     = high_time_lower_byte;
    next_lu     = low_time_upper_byte;
    next_ll     = low_time_lower_byte;
    next_ack    = req;
    next_rdata  = '0;
    if (wr && hit(wb_adr_in, FSG_IDX_CTL)) begin
      next_src    = wb_dat_in[FSG_SRC_LSB +: 4];
      next_idle   = wb_dat_in[FSG_BIT_IDLE];
      next_scheme = wb_dat_in[FSG_BIT_SCHEME];
      next_en     = wb_dat_in[FSG_BIT_ENABLE];
      next_shot   = wb_dat_in[FSG_BIT_SHOT];
    end
    if (wr && hit(wb_adr_in, FSG_IDX_HI_UP)) next_hu = wb_dat_in[7:0];
    if (wr && hit(wb_adr_in, FSG_IDX_HI_LO)) next_hl = wb_dat_in[7:0];
    if (wr && hit(wb_adr_in, FSG_IDX_LO_UP)) next_lu = wb_dat_in[7:0];
    if (wr && hit(wb_adr_in, FSG_IDX_LO_LO)) next_ll = wb_dat_in[7:0];
    if (req && !wb_we_in) begin
      if (hit(wb_adr_in, FSG_IDX_CTL)) begin
        next_rdata[7:0] = {sync_source_select, 1'b0, idle_level,
                           period_scheme, periodic_generator_enable};
      end else if (hit(wb_adr_in, FSG_IDX_HI_UP)) begin
        next_rdata[7:0] = high_time_upper_byte;
      end else if (hit(wb_adr_in, FSG_IDX_HI_LO)) begin
        next_rdata[7:0] = high_time_lower_byte;
      end else if (hit(wb_adr_in, FSG_IDX_LO_UP)) begin
        next_rdata[7:0] = low_time_upper_byte;
      end else if (hit(wb_adr_in, FSG_IDX_LO_LO)) begin
        next_rdata[7:0] = low_time_lower_byte;
      end else if (hit(wb_adr_in, FSG_IDX_STATUS)) begin
        next_rdata[7:0] = {5'h0, state != FSG_IDLE, sync_q, state == FSG_SHOT};
      end else begin
        next_rdata = '0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync_source_select        <= 4'h0;
      idle_level                <= 1'b0;
      period_scheme             <= 1'b0;
      periodic_generator_enable <= 1'b0;
      one_shot_pulse            <= 1'b0;
      high_time_upper_byte      <= FSG_RESET_BYTE;
      high_time_lower_byte      <= FSG_RESET_BYTE;
      low_time_upper_byte       <= FSG_RESET_BYTE;
      low_time_lower_byte       <= FSG_RESET_BYTE;
      ack                       <= 1'b0;
      rdata                     <= '0;
    end else begin
      sync_source_select        <= next_src;
      idle_level                <= next_idle;
      period_scheme             <= next_scheme;
      periodic_generator_enable <= next_en;
      one_shot_pulse            <= next_shot;
      high_time_upper_byte      <= next_hu;
      high_time_lower_byte      <= next_hl;
      low_time_upper_byte       <= next_lu;
      low_time_lower_byte       <= next_ll;
      ack                       <= next_ack;
      rdata                     <= next_rdata;
    end
  end

  assign wb_ack_out = ack;
  assign wb_dat_out = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers and reference tick
  logic [7:0] sync_lvl;
  logic       f0_q, f1_q;
  logic [2:0] div_cnt;
  logic [2:0] next_div;
  logic       fix_tick;

  fsg_sync3 #(.W(8)) u_sync (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .async_in  ({port1_frame_clk_in, port0_frame_clk_in, general_pin_in}),
    .level_out (sync_lvl)
  );

  always_comb begin
    next_div = (div_cnt == 3'(FSG_FIX_DIV - 1)) ? 3'h0 : div_cnt + 3'h1;
  end

  assign fix_tick = (div_cnt == 3'(FSG_FIX_DIV - 1));

  logic ext_mode, fix_mode, ref_tick, ext_lvl;
  logic [2:0] pin_idx;
  assign ext_mode = sync_source_select[3] == FSG_SRC_EXT;
  assign fix_mode = sync_source_select[3:2] == FSG_SRC_FIX;
  assign pin_idx  = (sync_source_select == FSG_SRC_EXT5B) ? 3'd5 : sync_source_select[2:0];
  assign ext_lvl  = (pin_idx < 3'(FSG_NUM_GPIO)) ? sync_lvl[pin_idx] : 1'b0;

  always_comb begin
    if (fix_mode) begin
      ref_tick = fix_tick;
    end else if (sync_source_select == FSG_SRC_PORT0) begin
      ref_tick = sync_lvl[6] && !f0_q;
    end else if (sync_source_select == FSG_SRC_PORT1) begin
      ref_tick = sync_lvl[7] && !f1_q;
    end else begin
      ref_tick = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // generator
  logic [23:0] cnt;
  logic [23:0] next_cnt;
  fsg_state_e  next_state;
  logic        next_sync;
  logic [23:0] hi_load, lo_load;
  logic        shot_pend, next_pend;

  always_comb begin
    if (period_scheme) begin
      hi_load = {high_time_lower_byte, low_time_upper_byte, low_time_lower_byte};
      lo_load = hi_load;
    end else begin
      hi_load = {8'h0, high_time_upper_byte, high_time_lower_byte};
      lo_load = {8'h0, low_time_upper_byte, low_time_lower_byte};
    end
  end

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_sync  = sync_q;
    next_pend  = shot_pend || one_shot_pulse;
    case (state)
      FSG_IDLE: begin
        next_sync = idle_level;
        if (periodic_generator_enable && ref_tick) begin
          next_state = idle_level ? FSG_HIGH : FSG_LOW;
          next_cnt   = idle_level ? hi_load : lo_load;
        end else if (shot_pend && ref_tick) begin
          next_state = FSG_SHOT;
          next_cnt   = idle_level ? lo_load : hi_load;
          next_sync  = !idle_level;
          next_pend  = one_shot_pulse;
        end
      end
      FSG_HIGH, FSG_LOW: begin
        if (!periodic_generator_enable) begin
          next_state = FSG_IDLE;
          next_sync  = idle_level;
        end else if (ref_tick) begin
          if (cnt == 24'h0) begin
            next_state = (state == FSG_HIGH) ? FSG_LOW : FSG_HIGH;
            next_cnt   = (state == FSG_HIGH) ? lo_load : hi_load;
            next_sync  = (state == FSG_LOW);
          end else begin
            next_cnt = cnt - 24'h1;
          end
        end
      end
      FSG_SHOT: begin
        if (ref_tick) begin
          if (cnt == 24'h0) begin
            next_state = FSG_IDLE;
            next_sync  = idle_level;
          end else begin
            next_cnt = cnt - 24'h1;
          end
        end
      end
      default: next_state = FSG_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state     <= FSG_IDLE;
      cnt       <= '0;
      sync_q    <= 1'b0;
      shot_pend <= 1'b0;
      div_cnt   <= '0;
      f0_q      <= 1'b0;
      f1_q      <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      sync_q    <= next_sync;
      shot_pend <= next_pend;
      div_cnt   <= next_div;
      f0_q      <= sync_lvl[6];
      f1_q      <= sync_lvl[7];
    end
  end

  logic out_q;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      out_q <= 1'b0;
    end else begin
      out_q <= ext_mode ? ext_lvl : sync_q;
    end
  end
  assign frame_trigger_out = out_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_shot_clears;
    @(posedge clk_in) disable iff (!rstn_in) one_shot_pulse |=> !one_shot_pulse;
  endproperty
  a_shot_clears: assert property (p_shot_clears) else $error("one-shot did not clear");

  property p_ctl_read_zero;
    @(posedge clk_in) disable iff (!rstn_in)
      (req && !wb_we_in && hit(wb_adr_in, FSG_IDX_CTL)) |=> !wb_dat_out[FSG_BIT_SHOT];
  endproperty
  a_ctl_read_zero: assert property (p_ctl_read_zero) else $error("one-shot read nonzero");

  property p_rsvd_zero;
    @(posedge clk_in) disable iff (!rstn_in)
      (req && !wb_we_in && hit(wb_adr_in, FSG_IDX_RESERVED)) |=> wb_dat_out == 32'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved byte not zero");

  property p_idle_level;
    @(posedge clk_in) disable iff (!rstn_in)
      (state == FSG_IDLE && $past(state) == FSG_IDLE && $past(idle_level) == idle_level) |-> sync_q == idle_level;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level wrong");

  property p_disable_stops;
    @(posedge clk_in) disable iff (!rstn_in)
      (!periodic_generator_enable && (state == FSG_HIGH || state == FSG_LOW)) |=> state == FSG_IDLE;
  endproperty
  a_disable_stops: assert property (p_disable_stops) else $error("generator kept running");

  property p_high_reload;
    @(posedge clk_in) disable iff (!rstn_in)
      (state == FSG_LOW && periodic_generator_enable && ref_tick && cnt == 24'h0)
        |=> state == FSG_HIGH && cnt == $past(hi_load) && sync_q;
  endproperty
  a_high_reload: assert property (p_high_reload) else $error("high reload wrong");

  property p_low_reload;
    @(posedge clk_in) disable iff (!rstn_in)
      (state == FSG_HIGH && periodic_generator_enable && ref_tick && cnt == 24'h0)
        |=> state == FSG_LOW && cnt == $past(lo_load) && !sync_q;
  endproperty
  a_low_reload: assert property (p_low_reload) else $error("low reload wrong");

  property p_half_period;
    @(posedge clk_in) disable iff (!rstn_in)
      (period_scheme && periodic_generator_enable && ref_tick && cnt == 24'h0
        && (state == FSG_HIGH || state == FSG_LOW))
        |=> cnt == {$past(high_time_lower_byte), $past(low_time_upper_byte), $past(low_time_lower_byte)};
  endproperty
  a_half_period: assert property (p_half_period) else $error("shared period wrong");

  property p_ext_pass;
    @(posedge clk_in) disable iff (!rstn_in)
      (ext_mode && $stable(sync_source_select)) |=> frame_trigger_out == $past(ext_lvl);
  endproperty
  a_ext_pass: assert property (p_ext_pass) else $error("external sync not passed");

  property p_fix_tick;
    @(posedge clk_in) disable iff (!rstn_in) fix_tick |=> !fix_tick [*4];
  endproperty
  a_fix_tick: assert property (p_fix_tick) else $error("fixed reference rate wrong");

endmodule : fsg_frame_sync_generator

// ===== test/fsg_ref_model.sv
/*
  fsg_ref_model: far-side sources for the frame sync generator.
  assumes: free-running back-channel frame clocks, pin levels set by the bench.
*/
`timescale 1ns/1ps
module fsg_ref_model #(
  parameter int P0_NS = 56,
  parameter int P1_NS = 72
) (
  input  wire logic [5:0] pin_level_in,
  output logic            port0_clk_out,
  output logic            port1_clk_out,
  output logic [5:0]      general_pin_out
);
  // frame clocks, one reference tick per rising edge, phase unrelated to clk_in
  initial begin
    port0_clk_out = 1'b0;
    forever #(P0_NS / 2 + 0.3) port0_clk_out = ~port0_clk_out;
  end
  initial begin
    port1_clk_out = 1'b0;
    forever #(P1_NS / 2 + 0.7) port1_clk_out = ~port1_clk_out;
  end
  // pins follow the remote sensor level
  assign general_pin_out = pin_level_in;
endmodule : fsg_ref_model

// ===== test/fsg_frame_sync_generator_tb.sv
/*
  fsg_frame_sync_generator_tb: self-checking bench for the frame sync generator.
  assumes: fsg_pkg, fsg_frame_sync_generator and fsg_ref_model compiled first.
*/
`timescale 1ns/1ps
module fsg_frame_sync_generator_tb
  import fsg_pkg::*;
;
  logic        clk_in     = 1'b0;
  logic        rstn_in    = 1'b0;
  logic        wb_cyc_in  = 1'b0;
  logic        wb_stb_in  = 1'b0;
  logic        wb_we_in   = 1'b0;
  logic [31:0] wb_adr_in  = 32'h0;
  logic [31:0] wb_dat_in  = 32'h0;
  logic [3:0]  wb_sel_in  = 4'h0;
  logic [5:0]  pin_level  = 6'h0;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out;
  logic        port0_clk;
  logic        port1_clk;
  logic [5:0]  general_pin;
  logic        frame_trigger_out;
  logic [31:0] seed;
  logic [31:0] r;
  int          num_errors = 0;
  int          tests_run  = 0;
  int          hw;
  int          lw;
  int          k;

  always #4 clk_in = ~clk_in;

  fsg_frame_sync_generator uut (
    .clk_in             (clk_in),
    .rstn_in            (rstn_in),
    .wb_cyc_in          (wb_cyc_in),
    .wb_stb_in          (wb_stb_in),
    .wb_we_in           (wb_we_in),
    .wb_adr_in          (wb_adr_in),
    .wb_dat_in          (wb_dat_in),
    .wb_sel_in          (wb_sel_in),
    .wb_dat_out         (wb_dat_out),
    .wb_ack_out         (wb_ack_out),
    .port0_frame_clk_in (port0_clk),
    .port1_frame_clk_in (port1_clk),
    .general_pin_in     (general_pin),
    .frame_trigger_out  (frame_trigger_out)
  );

  fsg_ref_model partner (
    .pin_level_in    (pin_level),
    .port0_clk_out   (port0_clk),
    .port1_clk_out   (port1_clk),
    .general_pin_out (general_pin)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // phase length in clocks for a programmed value and clocks per tick
  function automatic int exp_w(input int n, input int div);
    return (n + 1) * div;
  endfunction : exp_w

  task automatic report_and_stop;
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // width within tol clocks, for asynchronous frame clocks
  task automatic near(input string what, input int w, input int e, input int tol);
    check(what, (w >= e - tol && w <= e + tol) ? 32'(e) : 32'(w), 32'(e));
  endtask : near

  // classic single cycle; ack and read data taken at the same rising edge
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= {22'h0, idx, 2'b00};
    wb_dat_in <= {24'h0, d};
    wb_sel_in <= 4'hf;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    if (n >= 50) check("wb_ack", 32'h0, 32'h1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    wb(1'b1, idx, d, x);
  endtask : wr

  // next full high phase and the low phase that follows, bounded by lim
  task automatic phases(input int lim, output int h, output int l);
    int n;
    n = 0;
    h = 0;
    l = 0;
    while (frame_trigger_out === 1'b1 && n < lim) begin @(negedge clk_in); n++; end
    while (frame_trigger_out !== 1'b1 && n < lim) begin @(negedge clk_in); n++; end
    while (frame_trigger_out === 1'b1 && h < lim) begin @(negedge clk_in); h++; end
    while (frame_trigger_out !== 1'b1 && l < lim) begin @(negedge clk_in); l++; end
  endtask : phases

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(8 * 30000);
    num_errors++;
    report_and_stop();
  end

  initial begin
    seed = 32'h67cc;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    // reset values and reserved slot
    for (int i = 8'h17; i <= 8'h1c; i++) begin
      wb(1'b0, 8'(i), 8'h0, r);
      check("reset_value", r, 32'h0);
    end
    wr(FSG_IDX_RESERVED, 8'hff);
    wb(1'b0, FSG_IDX_RESERVED, 8'h0, r);
    check("reserved_slot", r, 32'h0);
    wr(8'h30, 8'h5a);
    wb(1'b0, 8'h30, 8'h0, r);
    check("unmapped", r, 32'h0);
    // random time bytes read back at their own offsets
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr(8'h19 + 8'(seed[9:8]), seed[7:0]);
      wb(1'b0, 8'h19 + 8'(seed[9:8]), 8'h0, r);
      check("time_byte", r, {24'h0, seed[7:0]});
    end
    // single shot, enable left low, high time 1
    wr(FSG_IDX_HI_UP, 8'h00);
    wr(FSG_IDX_HI_LO, 8'h01);
    wr(FSG_IDX_LO_UP, 8'h00);
    wr(FSG_IDX_LO_LO, 8'h00);
    wr(FSG_IDX_CTL, 8'h40);
    wr(FSG_IDX_CTL, 8'h48);
    phases(200, hw, lw);
    check("shot_width", 32'(hw), 32'(exp_w(1, 5)));
    check("shot_count", 32'(lw), 32'd200);
    wb(1'b0, FSG_IDX_CTL, 8'h0, r);
    check("ctl_readback", r, 32'h40);
    // corner: high 1 tick, low upper byte only
    wr(FSG_IDX_HI_LO, 8'h00);
    wr(FSG_IDX_LO_UP, 8'h01);
    wr(FSG_IDX_CTL, 8'h41);
    phases(2000, hw, lw);
    near("hi_one_tick", hw, exp_w(0, 5), 0);
    near("lo_upper", lw, exp_w(256, 5), 0);
    wr(FSG_IDX_LO_UP, 8'h00);
    // random phases on the fixed reference, only code 4'h4 from this seed
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(FSG_IDX_CTL, 8'h00);
      wr(FSG_IDX_HI_LO, {5'h0, seed[2:0]});
      wr(FSG_IDX_LO_LO, {5'h0, seed[5:3]});
      wr(FSG_IDX_CTL, {seed[6] ? 4'h6 : 4'h4, 4'h1});
      phases(400, hw, lw);
      near("hi_width", hw, exp_w(int'(seed[2:0]), 5), 0);
      near("lo_width", lw, exp_w(int'(seed[5:3]), 5), 0);
      phases(400, hw, lw);
      near("hi_reload", hw, exp_w(int'(seed[2:0]), 5), 0);
    end
    // shared half period; high upper byte must not count
    wr(FSG_IDX_CTL, 8'h00);
    wr(FSG_IDX_HI_UP, 8'hff);
    wr(FSG_IDX_HI_LO, 8'h00);
    wr(FSG_IDX_LO_LO, 8'h02);
    wr(FSG_IDX_CTL, 8'h43);
    phases(400, hw, lw);
    near("half_hi", hw, exp_w(2, 5), 0);
    near("half_lo", lw, exp_w(2, 5), 0);
    // disabled generator stays still
    wr(FSG_IDX_CTL, 8'h42);
    repeat (20) @(negedge clk_in);
    phases(100, hw, lw);
    check("disabled_still", 32'(hw), 32'h0);
    wb(1'b0, FSG_IDX_STATUS, 8'h0, r);
    check("status_idle", r, 32'h0);
    // idle level one starts high
    wr(FSG_IDX_CTL, 8'h45);
    repeat (2) @(negedge clk_in);
    check("idle_high", {31'h0, frame_trigger_out}, 32'h1);
    // back-channel frame clocks of both ports
    wr(FSG_IDX_CTL, 8'h00);
    wr(FSG_IDX_HI_UP, 8'h00);
    wr(FSG_IDX_HI_LO, 8'h01);
    wr(FSG_IDX_LO_LO, 8'h01);
    wr(FSG_IDX_CTL, 8'h01);
    phases(600, hw, lw);
    near("port0_hi", hw, exp_w(1, 7), 1);
    wr(FSG_IDX_CTL, 8'h00);
    wr(FSG_IDX_CTL, 8'h11);
    phases(600, hw, lw);
    near("port1_hi", hw, exp_w(1, 9), 1);
    // external pins, reserved codes never written
    for (int c = 8; c <= 14; c++) begin
      k = (c == 14) ? 5 : c - 8;
      seed = lfsr(seed);
      @(posedge clk_in);
      pin_level <= seed[5:0];
      wr(FSG_IDX_CTL, {4'(c), 4'h0});
      repeat (8) @(negedge clk_in);
      check("ext_level", {31'h0, frame_trigger_out}, {31'h0, seed[k]});
      @(posedge clk_in);
      pin_level[k] <= ~seed[k];
      repeat (8) @(negedge clk_in);
      check("ext_flip", {31'h0, frame_trigger_out}, {31'h0, ~seed[k]});
    end
    report_and_stop();
  end
endmodule : fsg_frame_sync_generator_tb
